//--- hw/ep0_tx_path.sv
/*
  Endpoint 0 transmit path: APB registers, 8-byte payload FIFO, IN token
  response engine, purge and NAK flags, interrupt.
  Assumes a serial interface engine on pclk that decodes tokens, builds
  PID and CRC16 and reports handshakes; receive side supplies its arm and
  purge bits.
  Read data and slave error are registered at the setup edge, so the slave
  answers with no wait state and each read sees one consistent snapshot.
  Firmware should not push bytes while a packet is on the bus: the byte
  count would move under the serialiser and could end the packet late.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "ep0_tx_consts.svh"
module ep0_tx_path #(
  parameter int ADDR_W = 16,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial engine side
  input wire ep0_tx_pkg::sie_ev_t sie_ev,
  input wire logic pkt_ready,
  input wire logic ep_stall,
  output ep0_tx_pkg::tx_pkt_t pkt,
  // Receive side of endpoint 0
  input wire logic rx_arm,
  input wire logic rx_purge_req,
  output logic purge_done,
  // Interrupt
  output logic irq
);
  // Count width holds 0..DEPTH; pointer width wraps at DEPTH
  // DEPTH is expected to be a power of two so the pointers wrap cleanly
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [31:0] idx);
    logic [33:0] a;
    // Upper bits of the product fall away with the address width
    a = {idx, 2'b00};
    return a[ADDR_W-1:0];
  endfunction

  // Transmit engine and payload store
  ep0_tx_pkg::tx_state_t state_ff, nxt_state;
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] nxt_mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0] used_ff, nxt_used;

  // Control register bits
  logic ign_in_ff, nxt_ign_in;
  logic pid_sel_ff, nxt_pid_sel;
  logic arm_ff, nxt_arm;
  logic purge_ff, nxt_purge;

  // Sticky status flags
  logic done_ff, nxt_done;
  logic ack_ff, nxt_ack;
  logic in_nak_ff, nxt_in_nak;
  logic out_nak_ff, nxt_out_nak;

  // Interrupt, purge strobe and bus answer
  logic [2:0] ists_ff, nxt_ists;
  logic [2:0] imask_ff, nxt_imask;
  logic purge_done_ff, nxt_purge_done;
  ep0_tx_pkg::tx_pkt_t pkt_ff, nxt_pkt;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;

  // Bus decode
  logic wr_en, rd_en, hit_data, hit_sts, hit_ctl, hit_nak, hit_ists, hit_imask;
  logic [CW-1:0] free_cnt;
  logic pop;

  // Writes and read clears act in the access phase only
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign free_cnt = CW'(DEPTH) - used_ff;

  // Address decode, one hit at most
  always_comb begin
    hit_data = 1'b0;
    hit_sts = 1'b0;
    hit_ctl = 1'b0;
    hit_nak = 1'b0;
    hit_ists = 1'b0;
    hit_imask = 1'b0;
    if (paddr == reg_addr(`IDX_TX_DATA)) begin
      hit_data = 1'b1;
    end else if (paddr == reg_addr(`IDX_TX_STATUS)) begin
      hit_sts = 1'b1;
    end else if (paddr == reg_addr(`IDX_TX_CONTROL)) begin
      hit_ctl = 1'b1;
    end else if (paddr == reg_addr(`IDX_NAK_STATUS)) begin
      hit_nak = 1'b1;
    end else if (paddr == `ADDR_IRQ_STATUS) begin
      hit_ists = 1'b1;
    end else if (paddr == `ADDR_IRQ_MASK) begin
      hit_imask = 1'b1;
    end
  end

  // Zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign prdata = rdata_ff;
  assign pslverr = err_ff;
  assign pkt = pkt_ff;
  assign purge_done = purge_done_ff;
  assign irq = |(ists_ff & imask_ff);
  // Byte leaves the FIFO when the serialiser takes it
  assign pop = (state_ff == ep0_tx_pkg::ST_SEND) && pkt_ff.valid && pkt_ready;

  // Read data and error are registered one cycle ahead: computed in setup
  always_comb begin
    // Reserved bits and write-only registers read as zero
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (psel && !penable && !pwrite) begin
      if (hit_sts) begin
        nxt_rdata[`TXS_ACK_BIT] = ack_ff;
        nxt_rdata[`TXS_DONE_BIT] = done_ff;
        nxt_rdata[`TXS_COUNT_MSB:0] = 5'(free_cnt);
      end else if (hit_ctl) begin
        nxt_rdata[`TXC_IGN_IN_BIT] = ign_in_ff;
        nxt_rdata[`TXC_PURGE_BIT] = purge_ff;
        nxt_rdata[`TXC_PID_BIT] = pid_sel_ff;
        nxt_rdata[`TXC_ARM_BIT] = arm_ff;
      end else if (hit_nak) begin
        nxt_rdata[`NAK_OUT_BIT] = out_nak_ff;
        nxt_rdata[`NAK_IN_BIT] = in_nak_ff;
      end else if (hit_ists) begin
        nxt_rdata[2:0] = ists_ff;
      end else if (hit_imask) begin
        nxt_rdata[2:0] = imask_ff;
      end
    end
    if (psel && !penable) begin
      nxt_err = !(hit_data || hit_sts || hit_ctl || hit_nak || hit_ists || hit_imask);
    end
  end

  // Next state of FIFO, control, flags and transmit engine
  always_comb begin
    logic tok, want_purge, start_pkt, fin, nak_in, nak_out;
    tok = 1'b0;
    want_purge = 1'b0;
    start_pkt = 1'b0;
    fin = 1'b0;
    nak_in = 1'b0;
    nak_out = 1'b0;
    nxt_state = state_ff;
    nxt_mem = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_used = used_ff;
    nxt_ign_in = ign_in_ff;
    nxt_pid_sel = pid_sel_ff;
    nxt_arm = arm_ff;
    nxt_purge = purge_ff;
    nxt_done = done_ff;
    nxt_ack = ack_ff;
    nxt_in_nak = in_nak_ff;
    nxt_out_nak = out_nak_ff;
    nxt_ists = ists_ff;
    nxt_imask = imask_ff;
    nxt_purge_done = 1'b0;
    // Stream strobes default low; PID select follows the control bit
    nxt_pkt = '0;
    nxt_pkt.pid_data1 = pid_sel_ff;
    // Register writes
    // Bytes beyond a full FIFO are dropped without an error
    if (wr_en && hit_data && used_ff != CW'(DEPTH)) begin
      nxt_mem[wr_ptr_ff] = pwdata[7:0];
      nxt_wr_ptr = PW'(wr_ptr_ff + 1'b1);
    end
    if (wr_en && hit_ctl) begin
      nxt_ign_in = pwdata[`TXC_IGN_IN_BIT];
      nxt_pid_sel = pwdata[`TXC_PID_BIT];
      nxt_arm = pwdata[`TXC_ARM_BIT];
      want_purge = pwdata[`TXC_PURGE_BIT];
    end
    // Mask and status share one layout: done, OUT NAK, IN NAK
    if (wr_en && hit_imask) begin
      nxt_imask = pwdata[2:0];
    end
    if (wr_en && hit_ists) begin
      nxt_ists = ists_ff & ~pwdata[2:0];
    end
    // Reads clear only what they reported: the snapshot was taken at the
    // setup edge, so a flag raised on that edge must survive the access.
    // A setting event below still wins over the clear.
    if (rd_en && hit_sts) begin
      nxt_done = done_ff && !rdata_ff[`TXS_DONE_BIT];
      nxt_ack = ack_ff && !rdata_ff[`TXS_ACK_BIT];
    end
    if (rd_en && hit_nak) begin
      nxt_in_nak = in_nak_ff && !rdata_ff[`NAK_IN_BIT];
      nxt_out_nak = out_nak_ff && !rdata_ff[`NAK_OUT_BIT];
    end
    // Either control register may request the shared purge
    if (want_purge || rx_purge_req) begin
      nxt_purge = 1'b1;
    end
    // Token qualified by the address enable and the ignore bit
    tok = sie_ev.in_token && sie_ev.addr_ok && !ign_in_ff;
    // Transmit engine
    case (state_ff)
      ep0_tx_pkg::ST_IDLE: begin
        if (tok) begin
          // Stall outranks everything, then the arm bit, else a NAK
          if (ep_stall) begin
            nxt_pkt.stall = 1'b1;
            nxt_arm = 1'b0;
          end else if (arm_ff && !rx_arm && !purge_ff) begin
            start_pkt = 1'b1;
          end else begin
            nxt_pkt.nak = 1'b1;
            nak_in = 1'b1;
          end
        end
      end
      ep0_tx_pkg::ST_SEND: begin
        // Arm falls as the end marker is taken
        if (pkt_ff.eop && pkt_ready) begin
          nxt_state = ep0_tx_pkg::ST_WAIT;
          nxt_arm = 1'b0;
        end
      end
      ep0_tx_pkg::ST_WAIT: begin
        // Either a handshake or its timeout ends the wait
        if (sie_ev.host_ack || sie_ev.ack_timeout) begin
          fin = 1'b1;
          nxt_state = ep0_tx_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ep0_tx_pkg::ST_IDLE;
      end
    endcase
    // Launch: the first byte is presented together with start
    if (start_pkt) begin
      nxt_state = ep0_tx_pkg::ST_SEND;
      nxt_pkt.start = 1'b1;
    end
    // Read pointer moves only on an accepted byte
    if (pop) begin
      nxt_rd_ptr = PW'(rd_ptr_ff + 1'b1);
    end
    // Occupancy follows the pointers, so push and pop may share a cycle
    nxt_used = CW'(used_ff + CW'(nxt_wr_ptr != wr_ptr_ff) - CW'(pop));
    // Stream presents the next byte while in SEND; an empty FIFO means a
    // zero-length packet goes straight to its end
    if (nxt_state == ep0_tx_pkg::ST_SEND && !(state_ff == ep0_tx_pkg::ST_SEND
        && pkt_ff.eop && pkt_ready)) begin
      nxt_pkt.valid = nxt_used != '0;
      nxt_pkt.data = nxt_mem[nxt_rd_ptr];
      nxt_pkt.eop = nxt_used == '0;
    end
    // End of the handshake wait: done always, ack only if the host sent one
    if (fin) begin
      nxt_done = 1'b1;
      if (sie_ev.host_ack) begin
        nxt_ack = 1'b1;
      end
    end
    // Overrun NAKs belong to the receive side and are not flagged here
    nak_out = sie_ev.out_nak && sie_ev.addr_ok && !sie_ev.out_overrun;
    if (nak_out) begin
      nxt_out_nak = 1'b1;
    end
    if (nak_in) begin
      nxt_in_nak = 1'b1;
    end
    // Purge only once the endpoint is idle, so a packet on the bus is whole
    if (purge_ff && state_ff == ep0_tx_pkg::ST_IDLE && !start_pkt) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_used = '0;
      nxt_purge = 1'b0;
      nxt_purge_done = 1'b1;
    end
    // Interrupt events are sticky; set wins over a software clear
    nxt_ists = nxt_ists | {fin, nak_out, nak_in};
  end

  // Register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ep0_tx_pkg::ST_IDLE;
      // Store is cleared too, so no stale byte can leak into a packet
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= 8'h00;
      end
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      used_ff <= '0;
      ign_in_ff <= 1'b0;
      pid_sel_ff <= 1'b0;
      arm_ff <= 1'b0;
      purge_ff <= 1'b0;
      done_ff <= 1'b0;
      ack_ff <= 1'b0;
      in_nak_ff <= 1'b0;
      out_nak_ff <= 1'b0;
      ists_ff <= 3'h0;
      imask_ff <= 3'h0;
      purge_done_ff <= 1'b0;
      pkt_ff <= '0;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mem_ff <= nxt_mem;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      used_ff <= nxt_used;
      ign_in_ff <= nxt_ign_in;
      pid_sel_ff <= nxt_pid_sel;
      arm_ff <= nxt_arm;
      purge_ff <= nxt_purge;
      done_ff <= nxt_done;
      ack_ff <= nxt_ack;
      in_nak_ff <= nxt_in_nak;
      out_nak_ff <= nxt_out_nak;
      ists_ff <= nxt_ists;
      imask_ff <= nxt_imask;
      purge_done_ff <= nxt_purge_done;
      pkt_ff <= nxt_pkt;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end
endmodule

//--- common/ep0_tx_consts.svh
/*
  Offsets, field positions, reset values and counts of the endpoint 0
  transmit path.
  Assumes it is included by its bare name wherever these are needed.
*/
// Summary of operation
// - Each write of the transmit data register pushes one byte; PID and CRC are generated. A write to a full FIFO is dropped.
// - Ack flag bit 6 sets on host ACK of last packet; status read clears it.
// - Send-complete bit 5 sets when the handshake wait ends (host ACK or timeout); status read clears it.
// - Bits 4:0 report free FIFO bytes, at most 8, reset value 8.
// - While ignore-IN bit 4 is set, IN tokens get no response at all.
// - Writing purge bit 3 empties FIFO, idles endpoint, zeroes pointers, then self-clears.
// - A purge requested mid-transfer waits until that transfer finishes.
// - Receive-side purge request has the very same effect as transmit purge.
// - Bit 2 picks DATA0 or DATA1 PID; hardware never changes it.
// - Firmware sets send-arm bit 0; hardware clears it after packet or STALL.
// - While receive-arm is set, send-arm is ignored.
// - Send-arm with an empty FIFO sends a zero-length data packet.
// - OUT NAK bit 1 sets on NAK to OUT for enabled address; read clears.
// - A NAK caused by receive overrun does not set the OUT NAK bit.
// - IN NAK bit 0 sets on NAK to IN for enabled address; read clears.
`ifndef EP0_TX_CONSTS_SVH
`define EP0_TX_CONSTS_SVH
// Printed offsets are register indices; byte address is four times the index
`define IDX_TX_DATA 32'h50001842
`define IDX_TX_STATUS 32'h50001844
`define IDX_TX_CONTROL 32'h50001846
`define IDX_NAK_STATUS 32'h50001848
`define ADDR_IRQ_STATUS 16'h6180
`define ADDR_IRQ_MASK 16'h6184
// Transmit status fields
`define TXS_ACK_BIT 6
`define TXS_DONE_BIT 5
`define TXS_COUNT_MSB 4
`define TXS_RESET 16'h0008
// Transmit control fields
`define TXC_IGN_IN_BIT 4
`define TXC_PURGE_BIT 3
`define TXC_PID_BIT 2
`define TXC_ARM_BIT 0
// NAK status fields, also the layout of irq status and mask
`define NAK_OUT_BIT 1
`define NAK_IN_BIT 0
`define IRQ_DONE_BIT 2
// FIFO
`define FIFO_DEPTH 8
`endif

//--- common/ep0_tx_pkg.sv
/*
  Types of the endpoint 0 transmit path.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ep0_tx_pkg;
  // Transmit engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } tx_state_t;

  // Events from the serial interface engine, same clock
  typedef struct packed {
    logic in_token;      // IN token to this endpoint, pulse
    logic addr_ok;       // Address and endpoint enabled, level
    logic host_ack;      // ACK received after our data, pulse
    logic ack_timeout;   // No handshake came back, pulse
    logic out_nak;       // NAK sent to an OUT token, pulse
    logic out_overrun;   // That NAK was due to overrun, level
  } sie_ev_t;

  // Packet stream towards the serialiser
  typedef struct packed {
    logic start;         // Begin data packet, pulse
    logic pid_data1;     // 0 DATA0, 1 DATA1
    logic valid;         // Payload byte present
    logic [7:0] data;
    logic eop;           // No bytes left, CRC and end follow
    logic nak;           // Send NAK handshake, pulse
    logic stall;         // Send STALL handshake, pulse
  } tx_pkt_t;
endpackage

//--- sim/ep0_tx_path_checker.sv
/*
  Port assertions for the endpoint 0 transmit path.
  Assumes it is bound into ep0_tx_path; one clock, async active-low reset.
*/
`timescale 1ns/100ps
module ep0_tx_path_checker #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Link side
  input wire ep0_tx_pkg::sie_ev_t sie_ev,
  input wire ep0_tx_pkg::tx_pkt_t pkt,
  input wire logic pkt_ready,
  input wire logic ep_stall,
  input wire logic rx_arm,
  input wire logic purge_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero-wait slave; only mapped words answer without error
  ready_zero_a:
    assert property (psel |-> pready && (penable || !pslverr))
    else $error("pready low or early error");
  slverr_map_a:
    assert property (psel && penable |-> pslverr == !(paddr inside {16'h6108, 16'h6110,
      16'h6118, 16'h6120, 16'h6180, 16'h6184})) else $error("pslverr wrong");
  // Answers follow an IN token by one cycle
  stall_cause_a:
    assert property (pkt.stall |-> $past(ep_stall) && $past(sie_ev.in_token))
    else $error("stall without cause");
  start_cause_a:
    assert property (pkt.start |-> $past(sie_ev.in_token) && !$past(rx_arm) && !$past(ep_stall))
    else $error("start without cause");
  nak_cause_a:
    assert property (pkt.nak |-> $past(sie_ev.in_token) && $past(sie_ev.addr_ok))
    else $error("nak without token");
  // Empty packet still carries its end marker
  zero_len_a:
    assert property (pkt.start && !pkt.valid |-> pkt.eop) else $error("empty start no eop");
  // Byte and PID hold until the serialiser takes them
  byte_hold_a:
    assert property (pkt.valid && !pkt_ready |=> pkt.valid && $stable(pkt.data)
      && $stable(pkt.pid_data1)) else $error("byte not held");
  eop_hold_a:
    assert property (pkt.eop && !pkt_ready |=> pkt.eop) else $error("eop not held");
  purge_idle_a:
    assert property (purge_done |-> !pkt.valid && !pkt.eop && !pkt.start)
    else $error("purge during transfer");
endmodule
bind ep0_tx_path ep0_tx_path_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .sie_ev, .pkt, .pkt_ready, .ep_stall, .rx_arm,
  .purge_done);

//--- sim/ep0_host_model.sv
/*
  Host side model: sends tokens on request, drains packets, answers ACK or timeout.
  Assumes the same clock as the block and calls of pulse right after an edge.
*/
`timescale 1ns/100ps
module ep0_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Packet stream and behaviour
  input wire ep0_tx_pkg::tx_pkt_t pkt,
  input wire logic slow,
  input wire logic ack_ok,
  // Events towards the block
  output ep0_tx_pkg::sie_ev_t ev,
  output logic pkt_ready
);
  logic ph;
  logic eop_seen;
  logic pid;
  logic [7:0] got[$];
  // Slow mode takes every other cycle so holding is exercised
  assign pkt_ready = slow ? ph : 1'b1;
  initial ev = 6'h10;
  // Capture payload; handshake one cycle after end of packet
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'b0;
      eop_seen <= 1'b0;
      ev.host_ack <= 1'b0;
      ev.ack_timeout <= 1'b0;
    end else begin
      ph <= ~ph;
      if (pkt.start) begin
        got.delete();
        pid <= pkt.pid_data1;
      end
      if (pkt.valid && pkt_ready) got.push_back(pkt.data);
      eop_seen <= pkt.eop && pkt_ready;
      ev.host_ack <= eop_seen && ack_ok;
      ev.ack_timeout <= eop_seen && !ack_ok;
    end
  end
  // One-cycle token or OUT NAK event: {in_token, out_nak, out_overrun}
  task automatic pulse(input logic [2:0] m);
    ev.in_token <= m[2];
    ev.out_nak <= m[1];
    ev.out_overrun <= m[0];
    @(posedge pclk);
    ev.in_token <= 1'b0;
    ev.out_nak <= 1'b0;
    ev.out_overrun <= 1'b0;
  endtask
endmodule

//--- sim/usb_ep0_transmit_path_test.sv
/*
  Self-checking bench for the endpoint 0 transmit path.
  Assumes the host model and checker files are compiled alongside.
*/
`timescale 1ns/100ps
`include "ep0_tx_consts.svh"
module usb_ep0_transmit_path_test;
  localparam logic [15:0] a_dat = 16'(`IDX_TX_DATA * 4);
  localparam logic [15:0] a_sts = 16'(`IDX_TX_STATUS * 4);
  localparam logic [15:0] a_ctl = 16'(`IDX_TX_CONTROL * 4);
  localparam logic [15:0] a_nak = 16'(`IDX_NAK_STATUS * 4);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic slow, ack_ok, pkt_ready, ep_stall, rx_arm, rx_purge_req;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  ep0_tx_pkg::sie_ev_t sie_ev;
  ep0_tx_pkg::tx_pkt_t pkt;
  int error_cnt, cmp_count, cyc;
  ep0_tx_path i_ep0_tx_path (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sie_ev, .pkt_ready, .ep_stall, .pkt, .rx_arm,
    .rx_purge_req, .purge_done(), .irq);
  ep0_host_model i_ep0_host_model (.pclk, .presetn, .pkt, .slow, .ack_ok, .ev(sie_ev),
    .pkt_ready);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("TB: %0d errors in %0d checks", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, got);
    end
  endtask
  // APB transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, r, e);
  endtask
  task automatic ichk(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask
  task automatic tok(input logic [2:0] m);
    i_ep0_host_model.pulse(m);
    repeat (2) @(posedge pclk);
  endtask
  // Poll until a packet is reported done; read clears the flags
  task automatic wdone();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a_sts, 32'h0);
      if (r[`TXS_DONE_BIT]) break;
    end
  endtask
  task automatic t_regs();
    rchk("sts", a_sts, 32'h8);
    rchk("ctl", a_ctl, 32'h0);
    rchk("nak", a_nak, 32'h0);
    apb(1'b0, 16'h6100, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask
  // Two bytes, slow drain, receive-side purge raised mid-transfer
  task automatic t_send();
    wr(a_dat, 32'hAA);
    wr(a_dat, 32'h55);
    rchk("cnt", a_sts, 32'h6);
    wr(a_ctl, 32'h5);
    slow <= 1'b1;
    i_ep0_host_model.pulse(3'h4);
    rx_purge_req <= 1'b1;
    @(posedge pclk);
    rx_purge_req <= 1'b0;
    wdone();
    chk("done", r, 32'h68);
    chk("b0", i_ep0_host_model.got[0], 32'hAA);
    chk("b1", i_ep0_host_model.got[1], 32'h55);
    chk("pid", {31'h0, i_ep0_host_model.pid}, 32'h1);
    rchk("clr", a_sts, 32'h8);
    rchk("ctl", a_ctl, 32'h4);
  endtask
  task automatic t_zlp();
    slow <= 1'b0;
    ack_ok <= 1'b0;
    wr(a_ctl, 32'h1);
    tok(3'h4);
    wdone();
    chk("zsts", r, 32'h28);
    chk("zlen", 32'(i_ep0_host_model.got.size()), 32'h0);
    chk("zpid", {31'h0, i_ep0_host_model.pid}, 32'h0);
    ack_ok <= 1'b1;
  endtask
  // Overfill, then purge through the control register
  task automatic t_purge();
    repeat (`FIFO_DEPTH + 1) wr(a_dat, 32'h11);
    rchk("full", a_sts, 32'h0);
    wr(a_ctl, 32'h8);
    rchk("flush", a_sts, 32'h8);
    rchk("self", a_ctl, 32'h0);
  endtask
  task automatic t_nak();
    tok(3'h4);
    ichk(1'b0);
    wr(`ADDR_IRQ_MASK, 32'h3);
    ichk(1'b1);
    rchk("in", a_nak, 32'h1);
    rchk("rc", a_nak, 32'h0);
    tok(3'h3);
    rchk("ovr", a_nak, 32'h0);
    tok(3'h2);
    rchk("out", a_nak, 32'h2);
    wr(`ADDR_IRQ_STATUS, 32'h7);
    ichk(1'b0);
    wr(a_ctl, 32'h1);
    rx_arm <= 1'b1;
    tok(3'h4);
    rx_arm <= 1'b0;
    rchk("rxarm", a_nak, 32'h1);
    ep_stall <= 1'b1;
    tok(3'h4);
    ep_stall <= 1'b0;
    rchk("stall", a_ctl, 32'h0);
    wr(a_ctl, 32'h10);
    tok(3'h4);
    rchk("ign", a_nak, 32'h0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, slow, ep_stall, rx_arm, rx_purge_req} = 8'h0;
    ack_ok = 1'b1;
    paddr = 16'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_send();
    t_zlp();
    t_purge();
    t_nak();
    summarize();
  end
endmodule
